// ==== core/mcidx_pkg.sv ====
// Package for the memory-controller indirect access port
package mcidx_pkg;
  localparam int          MCIDX_AW              = 8;
  localparam logic [7:0]  MCIDX_OFF_INDEX       = 8'h70;
  localparam logic [7:0]  MCIDX_OFF_DATA        = 8'h74;
  localparam logic [31:0] MCIDX_INDEX_RST       = 32'h0000_0000;
  localparam logic [31:0] MCIDX_DATA_RST        = 32'h0000_0000;
  localparam int          MCIDX_OFS_LSB         = 0;
  localparam int          MCIDX_OFS_MSB         = 15;
  localparam int          MCIDX_SEQ_LSB         = 16;
  localparam int          MCIDX_NSEQ            = 4;
  localparam int          MCIDX_AUX_BIT         = 20;
  localparam int          MCIDX_ARB_TOP_BIT     = 21;
  localparam int          MCIDX_ARB_BOT_BIT     = 22;
  localparam int          MCIDX_WR_PERMIT_BIT   = 23;
  localparam int          MCIDX_RD_INV_BIT      = 24;
  localparam int          MCIDX_NBLK            = 7;
  localparam logic [15:0] MCIDX_REACH_LO        = 16'h0010;
  localparam logic [15:0] MCIDX_REACH_HI        = 16'h0038;
  localparam logic [31:0] MCIDX_INDEX_WMASK     = 32'h01ff_ffff;
  typedef enum logic [1:0] {
    MCIDX_IDLE = 2'b00,
    MCIDX_WAIT = 2'b01
  } mcidx_state_e;
endpackage

// ==== core/mcidx_index_reg.sv ====
// Index register with field decode
`timescale 1ns/1ps
`default_nettype none
module mcidx_index_reg
  import mcidx_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Write side
  input  wire logic                 wr_stb,
  input  wire logic [31:0]          wr_data,
  // Decoded fields
  output logic      [31:0]          index_q,
  output logic      [15:0]          indirect_target_offset,
  output logic      [MCIDX_NBLK-1:0] block_select,
  output logic                      indirect_write_permit,
  output logic                      return_data_invert
);
  logic [31:0] index_r;

  // Index storage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      index_r <= MCIDX_INDEX_RST; // RL9
    end else if (wr_stb) begin
      index_r <= wr_data & MCIDX_INDEX_WMASK; // RL1
    end
  end

  assign index_q                = index_r;
  assign indirect_target_offset = index_r[MCIDX_OFS_MSB:MCIDX_OFS_LSB]; // RL1
  assign block_select           = index_r[MCIDX_ARB_BOT_BIT:MCIDX_SEQ_LSB]; // RL4
  assign indirect_write_permit  = index_r[MCIDX_WR_PERMIT_BIT]; // RL7
  assign return_data_invert     = index_r[MCIDX_RD_INV_BIT]; // RL8
endmodule
`default_nettype wire

// ==== core/mcidx_port.sv ====
// Memory-controller indirect index/data access port
// Contract
// RL1: Index register low sixteen bits hold target indirect offset.
// RL2: Data register reads and writes forward full word to selected offset.
// RL3: Software targets only the reachable offset range through the port.
// RL4: Four bits each include one sequencer return-bus block.
// RL5: One bit includes the auxiliary, converter and global return block.
// RL6: Two bits include top and bottom client arbitration blocks.
// RL7: Write-permit clear makes port read-only; set lets writes through.
// RL8: Return-invert set inverts returned data bitwise; clear passes it.
// RL9: Index and data registers read zero after reset.
`timescale 1ns/1ps
`default_nettype none
module mcidx_port
  import mcidx_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Configuration space access
  input  wire logic                  cfg_req,
  input  wire logic                  cfg_wr,
  input  wire logic [MCIDX_AW-1:0]   cfg_addr,
  input  wire logic [31:0]           cfg_wdata,
  output logic                       cfg_ack,
  output logic      [31:0]           cfg_rdata,
  // Indirect bus to memory controller
  output logic                       mc_req,
  output logic                       mc_wr,
  output logic      [15:0]           mc_offset,
  output logic      [MCIDX_NBLK-1:0] mc_block_select,
  output logic      [31:0]           mc_wdata,
  input  wire logic                  mc_ack,
  input  wire logic [31:0]           mc_rdata,
  // Status
  output logic                       offset_out_of_range
);
  logic [31:0]           index_q;
  logic [15:0]           indirect_target_offset;
  logic [MCIDX_NBLK-1:0] block_select;
  logic                  indirect_write_permit;
  logic                  return_data_invert;
  logic [31:0]           indirect_window_word_r;
  logic                  cfg_ack_r;
  logic [31:0]           cfg_rdata_r;
  logic                  mc_req_r;
  logic                  mc_wr_r;
  logic [31:0]           mc_wdata_r;
  mcidx_state_e          state_r;
  logic                  hit_index;
  logic                  hit_data;
  logic                  take;

  // Held request not taken again on its own ack cycle
  assign take      = cfg_req && !cfg_ack_r && (state_r == MCIDX_IDLE);
  assign hit_index = (cfg_addr == MCIDX_OFF_INDEX);
  assign hit_data  = (cfg_addr == MCIDX_OFF_DATA);

  mcidx_index_reg u_index (
    .ref_clk                (ref_clk),
    .rst                    (rst),
    .wr_stb                 (take && cfg_wr && hit_index),
    .wr_data                (cfg_wdata),
    .index_q                (index_q),
    .indirect_target_offset (indirect_target_offset),
    .block_select           (block_select),
    .indirect_write_permit  (indirect_write_permit),
    .return_data_invert     (return_data_invert)
  );

  // Sequencer of data accesses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= MCIDX_IDLE;
    end else begin
      case (state_r)
        MCIDX_IDLE: begin
          if (take && hit_data) begin
            state_r <= MCIDX_WAIT; // RL2
          end
        end
        MCIDX_WAIT: begin
          if (mc_ack) begin
            state_r <= MCIDX_IDLE;
          end
        end
        default: state_r <= MCIDX_IDLE;
      endcase
    end
  end

  // Indirect request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mc_req_r   <= 1'b0;
      mc_wr_r    <= 1'b0;
      mc_wdata_r <= MCIDX_DATA_RST;
    end else if (take && hit_data) begin
      mc_req_r   <= 1'b1; // RL2
      mc_wr_r    <= cfg_wr && indirect_write_permit; // RL7
      mc_wdata_r <= cfg_wdata;
    end else if (mc_ack) begin
      mc_req_r <= 1'b0;
      mc_wr_r  <= 1'b0;
    end
  end

  // Data register holds last transferred word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      indirect_window_word_r <= MCIDX_DATA_RST; // RL9
    end else if (state_r == MCIDX_WAIT && mc_ack) begin
      if (mc_wr_r) begin
        indirect_window_word_r <= mc_wdata_r;
      end else begin
        indirect_window_word_r <= return_data_invert ? ~mc_rdata : mc_rdata; // RL8
      end
    end
  end

  // Configuration answer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_ack_r   <= 1'b0;
      cfg_rdata_r <= MCIDX_DATA_RST;
    end else begin
      cfg_ack_r <= 1'b0;
      if (take && !hit_data) begin
        cfg_ack_r   <= 1'b1;
        cfg_rdata_r <= (hit_index && !cfg_wr) ? index_q : MCIDX_DATA_RST;
      end else if (state_r == MCIDX_WAIT && mc_ack) begin
        cfg_ack_r <= 1'b1;
        if (mc_wr_r) begin
          cfg_rdata_r <= MCIDX_DATA_RST;
        end else begin
          cfg_rdata_r <= return_data_invert ? ~mc_rdata : mc_rdata; // RL8
        end
      end
    end
  end

  assign cfg_ack         = cfg_ack_r;
  assign cfg_rdata       = cfg_rdata_r;
  assign mc_req          = mc_req_r;
  assign mc_wr           = mc_wr_r;
  assign mc_offset       = indirect_target_offset; // RL1
  assign mc_block_select = block_select; // RL4 RL5 RL6
  assign mc_wdata        = mc_wdata_r;
  // Flags offsets software should not target
  assign offset_out_of_range = (indirect_target_offset < MCIDX_REACH_LO) ||
                               (indirect_target_offset > MCIDX_REACH_HI); // RL3

  // Checks
  property p_wr_blocked;
    @(posedge ref_clk) disable iff (rst)
    (take && hit_data && cfg_wr && !indirect_write_permit) |=> (mc_req && !mc_wr);
  endproperty
  a_wr_blocked: assert property (p_wr_blocked) else $error("write passed while not permitted"); // RL7

  property p_wr_pass;
    @(posedge ref_clk) disable iff (rst)
    (take && hit_data && cfg_wr && indirect_write_permit) |=> (mc_req && mc_wr && mc_wdata == $past(cfg_wdata));
  endproperty
  a_wr_pass: assert property (p_wr_pass) else $error("permitted write not forwarded"); // RL2

  property p_rd_invert;
    @(posedge ref_clk) disable iff (rst)
    (state_r == MCIDX_WAIT && mc_ack && !mc_wr && return_data_invert) |=> (cfg_ack && cfg_rdata == ~$past(mc_rdata));
  endproperty
  a_rd_invert: assert property (p_rd_invert) else $error("return data not inverted"); // RL8

  property p_rd_plain;
    @(posedge ref_clk) disable iff (rst)
    (state_r == MCIDX_WAIT && mc_ack && !mc_wr && !return_data_invert) |=> (cfg_ack && cfg_rdata == $past(mc_rdata));
  endproperty
  a_rd_plain: assert property (p_rd_plain) else $error("return data altered"); // RL8

  property p_index_wr;
    @(posedge ref_clk) disable iff (rst)
    (take && cfg_wr && hit_index) |=> (mc_offset == $past(cfg_wdata[MCIDX_OFS_MSB:MCIDX_OFS_LSB]));
  endproperty
  a_index_wr: assert property (p_index_wr) else $error("offset not loaded from index write"); // RL1

  property p_blk_sel;
    @(posedge ref_clk) disable iff (rst)
    (take && cfg_wr && hit_index) |=> (mc_block_select == $past(cfg_wdata[MCIDX_ARB_BOT_BIT:MCIDX_SEQ_LSB]));
  endproperty
  a_blk_sel: assert property (p_blk_sel) else $error("block selects wrong"); // RL4 RL5 RL6

  property p_reset_zero;
    @(posedge ref_clk) $fell(rst) |-> (index_q == MCIDX_INDEX_RST && indirect_window_word_r == MCIDX_DATA_RST);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset"); // RL9

  property p_req_hold;
    @(posedge ref_clk) disable iff (rst)
    (mc_req && !mc_ack) |=> mc_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack"); // RL2

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (rst)
    cfg_ack |=> !cfg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle"); // RL2

  property p_idx_rd;
    @(posedge ref_clk) disable iff (rst)
    (take && hit_index && !cfg_wr) |=> (cfg_ack && cfg_rdata == $past(index_q));
  endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("index read back wrong"); // RL1

  property p_index_mask;
    @(posedge ref_clk) disable iff (rst)
    ((index_q & ~MCIDX_INDEX_WMASK) == MCIDX_INDEX_RST);
  endproperty
  a_index_mask: assert property (p_index_mask) else $error("unused index bits set"); // RL1

  property p_unmapped;
    @(posedge ref_clk) disable iff (rst)
    (take && !hit_index && !hit_data) |=> (cfg_ack && cfg_rdata == MCIDX_DATA_RST);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not answered with zero"); // RL2

  property p_reset_out;
    @(posedge ref_clk) $fell(rst) |-> (!mc_req && !cfg_ack);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs active after reset"); // RL9
endmodule
`default_nettype wire

// ==== tb/mcidx_mc_model.sv ====
// Memory-controller register sub-block model
`timescale 1ns/1ps
`default_nettype none
module mcidx_mc_model
  import mcidx_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Indirect bus
  input  wire logic        mc_req,
  input  wire logic        mc_wr,
  input  wire logic [15:0] mc_offset,
  input  wire logic [31:0] mc_wdata,
  input  wire logic [1:0]  delay,
  output logic             mc_ack,
  output logic      [31:0] mc_rdata
);
  logic [31:0] mem [64];
  logic [1:0]  cnt_r;
  initial foreach (mem[j]) mem[j] = 32'h0;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mc_ack <= 1'b0;
      mc_rdata <= 32'h5a5a_a5a5;
      cnt_r <= 2'h0;
    end else if (mc_req && !mc_ack && cnt_r >= delay) begin
      mc_ack <= 1'b1;
      mc_rdata <= mem[mc_offset[5:0]];
      cnt_r <= 2'h0;
      if (mc_wr) mem[mc_offset[5:0]] <= mc_wdata;
    end else begin
      mc_ack <= 1'b0;
      mc_rdata <= ~mc_rdata;
      cnt_r <= mc_req ? cnt_r + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the indirect access port
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mcidx_pkg::*;
;
  logic ref_clk, rst, cfg_req, cfg_wr, cfg_ack, mc_req, mc_wr, mc_ack, oor;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, mc_wdata, mc_rdata, v;
  logic [15:0] mc_offset, off;
  logic [MCIDX_NBLK-1:0] mc_block_select;
  logic [1:0]  delay;
  int          n_fail, total_checks, seed, idx, i;
  int          mem [64];
  mcidx_port dut (.ref_clk, .rst, .cfg_req, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_ack, .cfg_rdata,
    .mc_req, .mc_wr, .mc_offset, .mc_block_select, .mc_wdata, .mc_ack, .mc_rdata,
    .offset_out_of_range(oor));
  mcidx_mc_model mc (.ref_clk, .rst, .mc_req, .mc_wr, .mc_offset, .mc_wdata, .delay, .mc_ack,
    .mc_rdata);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One access, held until answered, then answer and far-side traffic checked
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic        dat, acked, got;
    logic [31:0] e;
    dat = (a == MCIDX_OFF_DATA);
    acked = 1'b0;
    got = 1'b0;
    e = 32'h0;
    if (a == MCIDX_OFF_INDEX && !w) e = idx;
    if (dat && !(w && idx[23])) e = mem[idx[5:0]] ^ {32{idx[24]}};
    @(posedge ref_clk);
    cfg_req <= 1'b1;
    cfg_wr <= w;
    cfg_addr <= a;
    cfg_wdata <= d;
    delay <= 2'($random(seed));
    for (int k = 0; k < 40 && !got; k++) begin
      @(posedge ref_clk);
      if (mc_ack) begin
        acked = 1'b1;
        chk("offset", {16'h0, idx[15:0]}, {16'h0, mc_offset});
        chk("select", {25'h0, idx[22:16]}, {25'h0, mc_block_select});
        chk("write", {31'h0, w && idx[23]}, {31'h0, mc_wr});
        if (w && idx[23]) chk("wdata", d, mc_wdata);
      end
      if (cfg_ack) begin
        got = 1'b1;
        cfg_req <= 1'b0;
        chk("forwarded", {31'h0, dat}, {31'h0, acked});
        chk("rdata", e, cfg_rdata);
      end
    end
    if (!got) begin
      cfg_req <= 1'b0;
      n_fail++;
      $display("mismatch answer expected ack seen none");
      close_out();
    end
    if (a == MCIDX_OFF_INDEX && w) idx = d & MCIDX_INDEX_WMASK;
    if (dat && w && idx[23]) mem[idx[5:0]] = d;
    chk("range", {31'h0, idx[15:0] < 16'h10 || idx[15:0] > 16'h38}, {31'h0, oor});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    seed = 32'hdd65;
    rst = 1'b1;
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h0;
    cfg_wdata = 32'h0;
    delay = 2'h0;
    n_fail = 0;
    total_checks = 0;
    idx = 0;
    foreach (mem[j]) mem[j] = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    acc(1'b0, MCIDX_OFF_INDEX, 32'h0);
    acc(1'b0, MCIDX_OFF_DATA, 32'h0);
    $display("test reset done");
    // Each select bit, permit, invert, an ignored bit; permit dropped last
    for (i = 0; i < 10; i++) begin
      off = 16'h10 + 16'({$random(seed)} % 41);
      v = {7'($random(seed)), 25'h0} | {16'h0, off} | (32'h1 << (16 + i));
      if (i < 9) v = v | 32'h0080_0000;
      acc(1'b1, MCIDX_OFF_INDEX, v);
      acc(1'b0, MCIDX_OFF_INDEX, 32'h0);
      acc(1'b1, MCIDX_OFF_DATA, $random(seed));
      acc(1'b0, MCIDX_OFF_DATA, 32'h0);
      $display("test select %0d done", i);
    end
    acc(1'b1, MCIDX_OFF_INDEX, 32'h40);
    acc(1'b1, 8'h78, $random(seed));
    acc(1'b0, 8'h78, 32'h0);
    $display("test range done");
    // Reset in mid-run brings both registers back to zero
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    idx = 0;
    acc(1'b0, MCIDX_OFF_INDEX, 32'h0);
    acc(1'b0, MCIDX_OFF_DATA, 32'h0);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
